// ### rtl/card_socket_present_state.sv
// Operation
// - Snapshot at offset 08h, read-only, writes ignored
// - Y and X supply capability read zero
// - 3.3 V and 5 V capability read one
// - Bits 27 to 14 read zero
// - Bits 13 to 10 card supply support
// - Support and type update only at probe end or by forcing write
// - Bit 9 flags invalid power request
// - Bit 8 flags possible removal data loss
// - Bit 7 unrecognized card, held until a valid probe or forcing write
// - Bit 6 mirrors ready/interrupt pin level
// - Bit 5 CardBus type, set by interrogation
// - Bit 4 legacy type, set by interrogation
// - Bit 3 socket powered state, default zero
// - Bit 2 detect pin b, frozen while interrogating
// - Bit 1 detect pin a, frozen while interrogating
// - Bit 0 mirrors status change pin
// - Forcing writes reflected in snapshot fields
// - Field changes set events, write one clears
// - Reinterrogate strobe re-probes, enables power control
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module card_socket_present_state
	import sock_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Socket pins, asynchronous
	input wire logic detect_pin_a,
	input wire logic detect_pin_b,
	input wire logic card_status_change_pin,
	input wire logic ready_irq_pin,
	// Interrogation sequencer
	output logic interrog_start,
	input wire logic interrog_busy,
	input wire logic interrog_done,
	input wire card_ident_t interrog_ident,
	// Power control and bridge status
	input wire logic socket_powered,
	input wire logic invalid_power_event,
	input wire logic removal_loss_event,
	output logic power_control_enable,
	output logic [3:0] event_flags
);

	// Cycles the launch pulse is held off after a start request
	localparam int LAUNCH_CYCLES_RAW = (LAUNCH_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int LAUNCH_CYCLES = (LAUNCH_CYCLES_RAW < 1) ? 1 : LAUNCH_CYCLES_RAW;

	// Address match helper, used by both write and read decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Two-stage synchroniser chains for the four pins
	logic [SYNC_STAGES-1:0] sync_a; // Detect a chain
	logic [SYNC_STAGES-1:0] sync_b; // Detect b chain
	logic [SYNC_STAGES-1:0] sync_s; // Status change chain
	logic [SYNC_STAGES-1:0] sync_r; // Ready/irq chain
	sock_pins_t pins; // Settled pin levels

	// Snapshot fields
	logic [3:0] socket_caps; // Supply capability, Y X 3V3 5V0
	logic [3:0] card_supports; // Card supply support, Y X 3V3 5V0
	logic invalid_power_request; // Bad power request
	logic removal_loss_flag; // Data possibly lost at removal
	logic unrecognized_card_flag; // Not a recognizable card
	logic ready_irq_pin_level; // Live ready/irq level
	logic cardbus_type_flag; // CardBus card present
	logic legacy_type_flag; // 16-bit card present
	logic socket_powered_flag; // Socket power state
	logic detect_pin_b_level; // Frozen-capable detect b
	logic detect_pin_a_level; // Frozen-capable detect a
	logic status_change_level; // Live status change level

	// Sequencing
	interrog_state_t state; // Launcher state
	interrog_state_t next_state; // Launcher next state
	logic [7:0] launch_count; // Settle counter
	logic interrogating; // Detect bits must not follow pins
	logic inserted; // Both detects low
	logic inserted_prev; // Previous insertion level

	// Write decode
	logic wr_event; // Write to event register
	logic wr_forcing; // Write to forcing register
	logic [3:0] ev_set; // Hardware event sets
	logic [31:0] snapshot; // Assembled snapshot word

	// Synchronise every pin before any logic reads it
	// The contacts bounce on insertion; the chain only removes metastability,
	// the detect freeze during probing deals with the bounce itself
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_a <= '1;
			sync_b <= '1;
			sync_s <= '0;
			sync_r <= '0;
		end else begin
			sync_a <= {sync_a[SYNC_STAGES-2:0], detect_pin_a};
			sync_b <= {sync_b[SYNC_STAGES-2:0], detect_pin_b};
			sync_s <= {sync_s[SYNC_STAGES-2:0], card_status_change_pin};
			sync_r <= {sync_r[SYNC_STAGES-2:0], ready_irq_pin};
		end
	end

	// Only the last stage is ever read
	always_comb begin
		pins.detect_a = sync_a[SYNC_STAGES-1];
		pins.detect_b = sync_b[SYNC_STAGES-1];
		pins.status_change = sync_s[SYNC_STAGES-1];
		pins.ready_irq = sync_r[SYNC_STAGES-1];
	end

	// Decode writes; writes to the snapshot address fall through and do nothing
	always_comb begin
		wr_event = 1'b0;
		wr_forcing = 1'b0;
		if (reg_wr && hit(reg_addr, OFS_EVENT)) begin
			wr_event = 1'b1;
		end else if (reg_wr && hit(reg_addr, OFS_FORCING)) begin
			wr_forcing = 1'b1;
		end
	end

	// Insertion is both detect pins low, seen on live pins
	// Waiting for both contacts keeps a card that enters at an angle from
	// launching a probe on its first contact
	assign inserted = ~pins.detect_a & ~pins.detect_b;

	// Remember insertion level to find the inserting edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			inserted_prev <= 1'b0;
		end else begin
			inserted_prev <= inserted;
		end
	end

	// Launcher next state: insertion or the reinterrogate strobe starts a probe
	// A strobe that arrives while a probe runs is dropped; the running probe
	// refreshes the same fields, so nothing is lost
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if ((inserted && !inserted_prev)
					|| (wr_forcing && reg_wdata[POS_REINTERROGATE])) begin
					next_state = ST_LAUNCH;
				end
			end
			ST_LAUNCH: begin
				if (launch_count == 8'(LAUNCH_CYCLES - 1)) begin
					next_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (interrog_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Launcher state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Settle counter runs only in launch
	// The settle time lets the detect contacts calm down before the
	// sequencer starts driving them
	always_ff @(posedge mclk) begin
		if (rst) begin
			launch_count <= 8'h00;
		end else if (state == ST_LAUNCH) begin
			launch_count <= launch_count + 8'h01;
		end else begin
			launch_count <= 8'h00;
		end
	end

	// Start pulse to the sequencer on leaving launch
	assign interrog_start = (state == ST_LAUNCH) && (next_state == ST_BUSY);

	// The detect pins are driven by the sequencer during probing, so freeze them
	assign interrogating = (state != ST_IDLE) || interrog_busy;

	// Power control enable: reinterrogate enables, a forced card supply bit disables
	// The strobe wins over supply bits in the same word, since the probe that
	// follows decides the card supply again
	always_ff @(posedge mclk) begin
		if (rst) begin
			power_control_enable <= 1'b1;
		end else if (wr_forcing && reg_wdata[POS_REINTERROGATE]) begin
			power_control_enable <= 1'b1;
		end else if (wr_forcing && (reg_wdata[POS_CARD_SUPPORTS_LO +: 4] != 4'h0)) begin
			power_control_enable <= 1'b0;
		end
	end

	// Capabilities are fixed; no forcing bit exists to override them
	always_ff @(posedge mclk) begin
		if (rst) begin
			socket_caps <= SOCKET_CAPS_RESET;
		end else begin
			socket_caps <= SOCKET_CAPS_RESET;
		end
	end

	// Card identity fields: probe result at its end, or forced by write
	// Between insertions software keeps seeing the last card's identity,
	// until the next probe ends or a forcing write lands
	always_ff @(posedge mclk) begin
		if (rst) begin
			card_supports <= SUPPORTS_RESET;
			cardbus_type_flag <= 1'b0;
			legacy_type_flag <= 1'b0;
		end else if (wr_forcing) begin
			card_supports <= reg_wdata[POS_CARD_SUPPORTS_LO +: 4];
			cardbus_type_flag <= reg_wdata[POS_CARDBUS_TYPE];
			legacy_type_flag <= reg_wdata[POS_LEGACY_TYPE];
		end else if (state == ST_BUSY && interrog_done) begin
			card_supports <= interrog_ident.supports;
			cardbus_type_flag <= interrog_ident.cardbus;
			legacy_type_flag <= interrog_ident.legacy;
		end
	end

	// Unrecognized card: set by a failed probe, cleared by a valid one, loaded from bit 7 by a forcing write
	always_ff @(posedge mclk) begin
		if (rst) begin
			unrecognized_card_flag <= 1'b0;
		end else if (wr_forcing) begin
			unrecognized_card_flag <= reg_wdata[POS_UNRECOGNIZED];
		end else if (state == ST_BUSY && interrog_done) begin
			unrecognized_card_flag <= ~interrog_ident.valid;
		end
	end

	// Invalid power request flag; a hardware event wins over a forced clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			invalid_power_request <= 1'b0;
		end else if (invalid_power_event) begin
			invalid_power_request <= 1'b1;
		end else if (wr_forcing) begin
			invalid_power_request <= reg_wdata[POS_INVALID_POWER];
		end
	end

	// Removal loss flag; same set-over-clear ordering
	always_ff @(posedge mclk) begin
		if (rst) begin
			removal_loss_flag <= 1'b0;
		end else if (removal_loss_event) begin
			removal_loss_flag <= 1'b1;
		end else if (wr_forcing) begin
			removal_loss_flag <= reg_wdata[POS_REMOVAL_LOSS];
		end
	end

	// Live pin levels and power state
	always_ff @(posedge mclk) begin
		if (rst) begin
			ready_irq_pin_level <= 1'b0;
			status_change_level <= 1'b0;
			socket_powered_flag <= 1'b0;
		end else begin
			ready_irq_pin_level <= pins.ready_irq;
			status_change_level <= pins.status_change;
			socket_powered_flag <= socket_powered;
		end
	end

	// Detect levels hold while probing, since the sequencer drives those pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			detect_pin_a_level <= 1'b1;
			detect_pin_b_level <= 1'b1;
		end else if (!interrogating) begin
			detect_pin_a_level <= pins.detect_a;
			detect_pin_b_level <= pins.detect_b;
		end
	end

	// Event sources: field changes, forced events; status edge rule by card type
	// Detect events are held back while probing; a real change during the
	// probe shows up as an event on the first cycle after it ends
	// CardBus cards report the rising status edge only, 16-bit cards both
	always_comb begin
		ev_set = 4'h0;
		ev_set[EV_POWER] = socket_powered_flag != socket_powered;
		ev_set[EV_DETECT_B] = !interrogating && (detect_pin_b_level != pins.detect_b);
		ev_set[EV_DETECT_A] = !interrogating && (detect_pin_a_level != pins.detect_a);
		if (cardbus_type_flag) begin
			ev_set[EV_STATUS] = !status_change_level && pins.status_change;
		end else begin
			ev_set[EV_STATUS] = status_change_level != pins.status_change;
		end
		if (wr_forcing) begin
			ev_set = ev_set | reg_wdata[EV_WIDTH-1:0];
		end
	end

	// Sticky events: write one clears, a same-cycle set wins
	// Keeping the set means no event is lost between a read and the clearing
	// write that software issues for it
	always_ff @(posedge mclk) begin
		if (rst) begin
			event_flags <= 4'h0;
		end else if (wr_event) begin
			event_flags <= (event_flags & ~reg_wdata[EV_WIDTH-1:0]) | ev_set;
		end else begin
			event_flags <= event_flags | ev_set;
		end
	end

	// Snapshot word assembly; unlisted bits stay zero
	always_comb begin
		snapshot = WORD_ZERO;
		snapshot[POS_SUPPLY_Y_CAP] = socket_caps[3];
		snapshot[POS_SUPPLY_X_CAP] = socket_caps[2];
		snapshot[POS_SUPPLY_3V3_CAP] = socket_caps[1];
		snapshot[POS_SUPPLY_5V0_CAP] = socket_caps[0];
		snapshot[POS_CARD_SUPPORTS_LO +: 4] = card_supports;
		snapshot[POS_INVALID_POWER] = invalid_power_request;
		snapshot[POS_REMOVAL_LOSS] = removal_loss_flag;
		snapshot[POS_UNRECOGNIZED] = unrecognized_card_flag;
		snapshot[POS_READY_IRQ] = ready_irq_pin_level;
		snapshot[POS_CARDBUS_TYPE] = cardbus_type_flag;
		snapshot[POS_LEGACY_TYPE] = legacy_type_flag;
		snapshot[POS_POWERED] = socket_powered_flag;
		snapshot[POS_DETECT_B] = detect_pin_b_level;
		snapshot[POS_DETECT_A] = detect_pin_a_level;
		snapshot[POS_STATUS_CHANGE] = status_change_level;
	end

	// Read data one cycle after the strobe, zero otherwise and for unmapped addresses
	// Zero outside the read cycle keeps stale data off the shared read bus
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= WORD_ZERO;
		end else if (!reg_rd) begin
			reg_rdata <= WORD_ZERO;
		end else if (hit(reg_addr, OFS_SNAPSHOT)) begin
			reg_rdata <= snapshot;
		end else if (hit(reg_addr, OFS_EVENT)) begin
			reg_rdata <= {28'h0000000, event_flags};
		end else begin
			reg_rdata <= WORD_ZERO;
		end
	end

endmodule : card_socket_present_state

`default_nettype wire

// ### rtl/sock_pkg.sv
package sock_pkg;

	// Register byte addresses inside the socket window
	localparam logic [7:0] OFS_EVENT = 8'h00;
	localparam logic [7:0] OFS_SNAPSHOT = 8'h08;
	localparam logic [7:0] OFS_FORCING = 8'h0C;

	// Snapshot register field positions
	localparam int POS_SUPPLY_Y_CAP = 31;
	localparam int POS_SUPPLY_X_CAP = 30;
	localparam int POS_SUPPLY_3V3_CAP = 29;
	localparam int POS_SUPPLY_5V0_CAP = 28;
	localparam int POS_CARD_SUPPORTS_LO = 10;
	localparam int POS_INVALID_POWER = 9;
	localparam int POS_REMOVAL_LOSS = 8;
	localparam int POS_UNRECOGNIZED = 7;
	localparam int POS_READY_IRQ = 6;
	localparam int POS_CARDBUS_TYPE = 5;
	localparam int POS_LEGACY_TYPE = 4;
	localparam int POS_POWERED = 3;
	localparam int POS_DETECT_B = 2;
	localparam int POS_DETECT_A = 1;
	localparam int POS_STATUS_CHANGE = 0;

	// Forcing register strobe position
	localparam int POS_REINTERROGATE = 14;

	// Event register bit positions
	localparam int EV_POWER = 3;
	localparam int EV_DETECT_B = 2;
	localparam int EV_DETECT_A = 1;
	localparam int EV_STATUS = 0;
	localparam int EV_WIDTH = 4;

	// Socket supply capabilities: Y and X unsupported, 3.3 V and 5 V supported
	localparam logic [3:0] SOCKET_CAPS_RESET = 4'h3;
	localparam logic [3:0] SUPPORTS_RESET = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	// Interrogation launch settle time
	localparam int LAUNCH_SETTLE_NS = 20;
	localparam int CLOCK_PERIOD_NS = 10;

	// Synchronised socket pin levels
	typedef struct packed {
		logic detect_a;
		logic detect_b;
		logic status_change;
		logic ready_irq;
	} sock_pins_t;

	// Card identity reported by the interrogation sequencer
	typedef struct packed {
		logic valid;
		logic cardbus;
		logic legacy;
		logic [3:0] supports;
	} card_ident_t;

	// Interrogation launcher states, Gray from idle through launch to busy, two bits back to idle
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_BUSY = 2'b11
	} interrog_state_t;

endpackage : sock_pkg

// ### testbench/sock_state_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sock_state_properties
	import sock_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Live socket pins
	input wire logic ready_irq_pin,
	input wire logic card_status_change_pin,
	// Sequencer, power and events
	input wire logic interrog_start,
	input wire logic interrog_busy,
	input wire logic interrog_done,
	input wire logic power_control_enable,
	input wire logic [3:0] event_flags
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// Edges since reset; pin checks wait out the synchroniser fill
	logic [2:0] since;
	// Reads taken last cycle, cleared by reset so no stale strobe counts
	logic pr_any;
	logic pr_snap;
	logic pr_frc;
	// Write to the forcing register
	logic frc_wr;
	assign frc_wr = reg_wr && reg_addr == OFS_FORCING;

	// Helper history
	always_ff @(posedge mclk) begin
		if (rst) begin
			since <= 3'h0;
			pr_any <= 1'h0;
			pr_snap <= 1'h0;
			pr_frc <= 1'h0;
		end else begin
			since <= (since == 3'h7) ? since : since + 3'h1;
			pr_any <= reg_rd;
			pr_snap <= reg_rd && reg_addr == OFS_SNAPSHOT;
			pr_frc <= reg_rd && reg_addr == OFS_FORCING;
		end
	end

	rd_idle_zero_a: assert property (!pr_any |-> reg_rdata == WORD_ZERO)
		else $error("read data not zero outside read cycle");
	socket_caps_a: assert property (pr_snap |-> reg_rdata[31:28] == 4'h3)
		else $error("socket supply capability bits wrong");
	reserved_zero_a: assert property (pr_snap |-> reg_rdata[27:14] == 14'h0)
		else $error("reserved snapshot bits not zero");
	forcing_zero_a: assert property (pr_frc |-> reg_rdata == WORD_ZERO)
		else $error("forcing register read not zero");
	ready_level_a: assert property ((since == 3'h7 && $stable(ready_irq_pin))[*5]
		##0 (reg_rd && reg_addr == OFS_SNAPSHOT) |=> reg_rdata[6] == $past(ready_irq_pin))
		else $error("ready level bit differs from pin");
	status_level_a: assert property ((since == 3'h7 && $stable(card_status_change_pin))[*5]
		##0 (reg_rd && reg_addr == OFS_SNAPSHOT) |=> reg_rdata[0] == $past(card_status_change_pin))
		else $error("status level bit differs from pin");
	probe_launch_a: assert property (frc_wr && reg_wdata[14] && !interrog_busy
		|=> !interrog_start ##1 interrog_start)
		else $error("probe not launched two cycles after strobe");
	power_on_a: assert property (frc_wr && reg_wdata[14] |=> power_control_enable)
		else $error("power control not enabled by strobe");
	power_off_a: assert property (frc_wr && !reg_wdata[14] && reg_wdata[13:10] != 4'h0
		|=> !power_control_enable)
		else $error("power control not disabled by forced support");
	force_event_a: assert property (frc_wr
		|=> (event_flags & $past(reg_wdata[3:0])) == $past(reg_wdata[3:0]))
		else $error("forced event not set");

	// Main scenarios reached
	cover property (interrog_done);
	cover property (pr_snap);
	cover property (frc_wr && reg_wdata[14]);
endmodule : sock_state_properties

bind card_socket_present_state sock_state_properties chk_u (.*);

`default_nettype wire

// ### testbench/card_socket_model.sv
`timescale 1ns/1ps
`default_nettype none

module card_socket_model
	import sock_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bench controls: presence, identity, answer delay
	input wire logic card_in,
	input wire card_ident_t id_in,
	input wire logic [3:0] dly,
	// Socket side
	input wire logic interrog_start,
	output logic detect_pin_a,
	output logic detect_pin_b,
	output logic interrog_busy,
	output logic interrog_done,
	output card_ident_t interrog_ident
);
	logic [3:0] cnt; // Probe cycles left
	logic tgl; // Contact bounce phase
	logic bnc; // Bounce on detect pins

	// Probe answer after a chosen delay, so prompt and slow cards are both seen
	always_ff @(posedge mclk) begin
		if (rst) begin
			interrog_busy <= 1'h0;
			interrog_done <= 1'h0;
			cnt <= 4'h0;
			tgl <= 1'h0;
		end else begin
			interrog_done <= 1'h0;
			tgl <= ~tgl;
			if (interrog_start) begin
				interrog_busy <= 1'h1;
				cnt <= dly;
			end else if (interrog_busy) begin
				cnt <= cnt - 4'h1;
				if (cnt == 4'h0) begin
					interrog_busy <= 1'h0;
					interrog_done <= 1'h1;
				end
			end
		end
	end

	// Pins bounce while probed, quiet well before the answer so sync lag is clear
	assign bnc = interrog_busy & (cnt > 4'h4) & tgl;
	assign detect_pin_a = ~card_in ^ bnc;
	assign detect_pin_b = ~card_in ^ bnc;
	// Identity is only meaningful with the done pulse; garbage otherwise
	assign interrog_ident = interrog_done ? id_in : ~id_in;
endmodule : card_socket_model

`default_nettype wire

// ### testbench/card_socket_present_state_tb.sv
`timescale 1ns/1ps
`default_nettype none

module card_socket_present_state_tb
	import sock_pkg::*;
;
	// Clock, reset and register port
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	// Pins, sequencer and bridge status
	logic ready_irq_pin = 1'h0;
	logic card_status_change_pin = 1'h0;
	logic socket_powered = 1'h0;
	logic invalid_power_event = 1'h0;
	logic removal_loss_event = 1'h0;
	logic detect_pin_a, detect_pin_b, interrog_start, interrog_busy, interrog_done;
	logic power_control_enable;
	logic [3:0] event_flags;
	card_ident_t interrog_ident;
	// Card model controls
	card_ident_t id_in = 7'h00;
	logic [3:0] dly = 4'h0;
	logic card_in = 1'h0;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;

	always #5 mclk = ~mclk;

	card_socket_present_state #(.SYNC_STAGES(2)) dut_u (.*);
	card_socket_model pm_u (.*);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask : rc

	// Bounded wait for probe busy or done
	task automatic wait_on(input logic want_done);
		logic hit;
		hit = 1'h0;
		for (int k = 0; k < 40 && !hit; k++) begin
			@(posedge mclk);
			#1 hit = want_done ? interrog_done : interrog_busy;
		end
		chk({31'h0, hit}, 32'h1);
	endtask : wait_on

	task automatic conclude();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	// Hang guard, well above the roughly 160 cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		// Empty socket, then ignored write, forcing and unmapped reads
		rc(OFS_SNAPSHOT, 32'h3000_0006);
		wr(OFS_SNAPSHOT, 32'hFFFF_FFFF);
		rc(OFS_SNAPSHOT, 32'h3000_0006);
		rc(OFS_FORCING, 32'h0);
		rc(8'h04, 32'h0);
		// Live pin levels
		@(posedge mclk);
		ready_irq_pin <= 1'h1;
		card_status_change_pin <= 1'h1;
		repeat (6) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_0047);
		rc(OFS_EVENT, 32'h1);
		wr(OFS_EVENT, 32'hF);
		rc(OFS_EVENT, 32'h0);
		// 16-bit card inserted, prompt answer
		@(posedge mclk);
		id_in <= 7'h53;
		card_in <= 1'h1;
		wait_on(1'h1);
		repeat (4) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_0C51);
		rc(OFS_EVENT, 32'h6);
		wr(OFS_EVENT, 32'hF);
		// Re-probe as CardBus, slow answer, pins bouncing meanwhile
		@(posedge mclk);
		id_in <= 7'h6C;
		dly <= 4'hC;
		wr(OFS_FORCING, 32'h4C10);
		wait_on(1'h0);
		repeat (3) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_0C51);
		wait_on(1'h1);
		repeat (4) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_3061);
		rc(OFS_EVENT, 32'h0);
		// CardBus status: falling edge ignored, rising edge counted
		@(posedge mclk);
		card_status_change_pin <= 1'h0;
		repeat (6) @(posedge mclk);
		rc(OFS_EVENT, 32'h0);
		@(posedge mclk);
		card_status_change_pin <= 1'h1;
		repeat (6) @(posedge mclk);
		rc(OFS_EVENT, 32'h1);
		// Forced fields and events
		wr(OFS_FORCING, 32'h0000_238F);
		rc(OFS_SNAPSHOT, 32'h3000_23C1);
		rc(OFS_EVENT, 32'hF);
		wr(OFS_EVENT, 32'hF);
		// Socket power comes up
		@(posedge mclk);
		socket_powered <= 1'h1;
		repeat (6) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_23C9);
		rc(OFS_EVENT, 32'h8);
		// Bridge status pulses after forced clear
		wr(OFS_FORCING, 32'h0);
		@(posedge mclk);
		invalid_power_event <= 1'h1;
		@(posedge mclk);
		invalid_power_event <= 1'h0;
		rc(OFS_SNAPSHOT, 32'h3000_0249);
		@(posedge mclk);
		removal_loss_event <= 1'h1;
		@(posedge mclk);
		removal_loss_event <= 1'h0;
		rc(OFS_SNAPSHOT, 32'h3000_0349);
		// Removal, then an unrecognisable card
		@(posedge mclk);
		card_in <= 1'h0;
		id_in <= 7'h00;
		dly <= 4'h2;
		repeat (8) @(posedge mclk);
		card_in <= 1'h1;
		wait_on(1'h1);
		repeat (4) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_03C9);
		// Re-probe with power control disabled: strobe must enable it again
		wr(OFS_FORCING, 32'h4000);
		wait_on(1'h1);
		repeat (4) @(posedge mclk);
		rc(OFS_SNAPSHOT, 32'h3000_00C9);
		conclude();
	end
endmodule : card_socket_present_state_tb

`default_nettype wire
